// File: hw/dlps_pkg.sv
// Package for the dual LED pulse sampling sequencer
// Assumes a 200 MHz system clock and an AHB-Lite register bus
package dlps_pkg;

	// ************************************************************
	// Register offsets (byte addresses)
	// ************************************************************
	localparam logic [7:0] CTRL_OFFSET      = 8'h00;
	localparam logic [7:0] RED_LEVEL_OFFSET = 8'h04;
	localparam logic [7:0] IR_LEVEL_OFFSET  = 8'h08;
	localparam logic [7:0] K_SHIFT_OFFSET   = 8'h0C;
	localparam logic [7:0] STATUS_OFFSET    = 8'h10;
	localparam logic [7:0] RED_DC_OFFSET    = 8'h14;
	localparam logic [7:0] IR_DC_OFFSET     = 8'h18;
	localparam logic [7:0] TIA_RESULT_OFFSET = 8'h1C;
	localparam logic [7:0] AC_RESULT_OFFSET = 8'h20;
	localparam logic [7:0] SEQ_COUNT_OFFSET = 8'h24;

	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam int CTRL_ENABLE_BIT      = 0;
	localparam int CTRL_PIN_SWAP_BIT    = 1;
	localparam logic [1:0] CTRL_RESET   = 2'h0;
	localparam logic [11:0] LEVEL_RESET = 12'h800;
	localparam logic [3:0] K_SHIFT_RESET = 4'h6;
	localparam logic [31:0] DC_RESET    = 32'h0800_0000;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLOCK_HZ          = 200_000_000;
	localparam int MUX_RATE_HZ       = 500;
	localparam int SAMPLE_RATE_HZ    = 2 * MUX_RATE_HZ;
	localparam int PERIOD_CYCLES     = CLOCK_HZ / SAMPLE_RATE_HZ;
	localparam int SETTLE_NS         = 1000;
	localparam int SETTLE_CYCLES     = (SETTLE_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
	localparam int CONV_CYCLES       = 16;

	// Sequencer states
	typedef enum logic [4:0] {
		ST_IDLE   = 5'b00001,
		ST_SETTLE = 5'b00010,
		ST_TIA    = 5'b00100,
		ST_AC     = 5'b01000,
		ST_OFF    = 5'b10000
	} dlps_state_type;

endpackage

// File: hw/dlps_conv_if.sv
// Interface between sequencer and sample converter model of conversion timing
// Assumes one clock shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface dlps_conv_if;
	logic start;
	logic [11:0] tia_in;
	logic [11:0] ac_in;
	logic done;
	logic [11:0] tia_result;
	logic [11:0] ac_result;
	modport seq (output start, tia_in, ac_in, input done, tia_result, ac_result);
	modport conv (input start, tia_in, ac_in, output done, tia_result, ac_result);
endinterface
`default_nettype wire

// File: hw/dlps_sample_conv.sv
// Two-sample conversion engine: transimpedance first, then AC gain stage
// Assumes inputs are synchronous samples of the converter front end
`timescale 1ns/1ps
`default_nettype none
module dlps_sample_conv #(
	parameter int CONV_CYCLES = dlps_pkg::CONV_CYCLES
) (
	// Clock and reset
	input  wire logic      hclk,
	input  wire logic      hresetn,
	// Sequencer side
	dlps_conv_if.conv      cv
);
	logic [7:0] count;
	logic       busy;
	logic       second;

	// Internal sample timer, multi_sample_bit behaviour: two back-to-back samples
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count         <= 8'h00;
			busy          <= 1'b0;
			second        <= 1'b0;
			cv.done       <= 1'b0;
			cv.tia_result <= 12'h000;
			cv.ac_result  <= 12'h000;
		end else begin
			cv.done <= 1'b0;
			if (cv.start && !busy) begin
				busy   <= 1'b1;
				second <= 1'b0;
				count  <= 8'(CONV_CYCLES - 1);
			end else if (busy) begin
				if (count != 8'h00) begin
					count <= count - 8'h01;
				end else if (!second) begin
					cv.tia_result <= cv.tia_in;   // R9
					second        <= 1'b1;
					count         <= 8'(CONV_CYCLES - 1);
				end else begin
					cv.ac_result <= cv.ac_in;     // R9
					busy         <= 1'b0;
					cv.done      <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: hw/dlps_sequencer.sv
// Dual LED pulse sampling sequencer with AHB-Lite register slave
// Assumes a single 200 MHz clock, analog front end inputs already sampled
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1: alternate red and infrared at 500 per second
// R2: complementary H-bridge select outputs
// R3: 12-bit drive level, steerable pin
// R4: unselected drive pin held low
// R5: timer paces sequence, starts conversion itself
// R6: compare event sets pin select, LED on
// R7: compare event loads selected LED intensity
// R8: compare event loads selected LED offset
// R9: two samples: transimpedance then AC gain
// R10: conversion done flags, then LED drive cleared
// R11: separate intensity level per LED
// R12: results tagged by LED for separation
// R13: AC stage sampled 1000 per second overall
// R14: DC tracking filter, 32-bit, upper 16 out
// R15: LED identity toggles, indexes per-LED values
module dlps_sequencer #(
	parameter int PERIOD_CYCLES = dlps_pkg::PERIOD_CYCLES,
	parameter int CONV_CYCLES   = dlps_pkg::CONV_CYCLES
) (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// LED H-bridge and converters
	output logic             led_select_a,
	output logic             led_select_b,
	output logic      [11:0] drive_pin_a,
	output logic      [11:0] drive_pin_b,
	output logic      [11:0] dc_offset_level,
	// Front end samples
	input  wire logic [11:0] tia_sample,
	input  wire logic [11:0] ac_sample,
	// Conversion event and result stream
	output logic             conversion_done,
	output logic             result_led_id,
	output logic      [11:0] result_tia,
	output logic      [11:0] result_ac
);
	// ************************************************************
	// Declarations
	// ************************************************************
	dlps_conv_if cif ();
	dlps_pkg::dlps_state_type state;
	dlps_pkg::dlps_state_type next_state;
	logic [31:0] period_count;
	logic        compare_event;
	logic [7:0]  settle_count;
	logic        led_id;
	logic        enable;
	logic        pin_swap;
	logic [11:0] level [2];
	logic [3:0]  k_shift;
	logic [31:0] dc_acc [2];
	logic [15:0] seq_count;
	logic        done_flag;
	logic        wr_pending;
	logic        rd_pending;
	logic [7:0]  addr_q;
	logic        access;
	logic        set_done;
	logic        clr_done;

	assign access = hsel && hready && htrans[1];

	dlps_sample_conv #(
		.CONV_CYCLES (CONV_CYCLES)
	) u_conv (
		.hclk    (hclk),
		.hresetn (hresetn),
		.cv      (cif)
	);
	assign cif.tia_in = tia_sample;
	assign cif.ac_in  = ac_sample;
	assign cif.start  = (state == dlps_pkg::ST_SETTLE) && (settle_count == 8'h00);  // R5

	// ************************************************************
	// Sequence timer
	// ************************************************************

	// Period counter: one compare event per 1 ms half of the multiplex
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			period_count  <= 32'h0000_0000;
			compare_event <= 1'b0;
		end else if (!enable) begin
			period_count  <= 32'h0000_0000;
			compare_event <= 1'b0;
		end else if (period_count == 32'(PERIOD_CYCLES - 1)) begin
			period_count  <= 32'h0000_0000;
			compare_event <= 1'b1;                     // R1 R13
		end else begin
			period_count  <= period_count + 32'h0000_0001;
			compare_event <= 1'b0;
		end
	end

	// LED identity toggles at each compare event
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			led_id <= 1'b0;
		end else if (compare_event) begin
			led_id <= ~led_id;                         // R15
		end
	end

	// ************************************************************
	// Sequencer state machine
	// ************************************************************

	// Next state
	always_comb begin
		next_state = state;
		case (state)
			dlps_pkg::ST_IDLE: begin
				if (compare_event) begin
					next_state = dlps_pkg::ST_SETTLE;
				end
			end
			dlps_pkg::ST_SETTLE: begin
				if (settle_count == 8'h00) begin
					next_state = dlps_pkg::ST_TIA;
				end
			end
			dlps_pkg::ST_TIA: begin
				next_state = dlps_pkg::ST_AC;
			end
			dlps_pkg::ST_AC: begin
				if (cif.done) begin
					next_state = dlps_pkg::ST_OFF;
				end
			end
			dlps_pkg::ST_OFF: begin
				next_state = dlps_pkg::ST_IDLE;
			end
			default: begin
				next_state = dlps_pkg::ST_IDLE;
			end
		endcase
	end

	// State register and settle counter
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state        <= dlps_pkg::ST_IDLE;
			settle_count <= 8'h00;
		end else begin
			state <= next_state;
			if (state == dlps_pkg::ST_IDLE && compare_event) begin
				settle_count <= 8'(dlps_pkg::SETTLE_CYCLES - 1);
			end else if (settle_count != 8'h00) begin
				settle_count <= settle_count - 8'h01;
			end
		end
	end

	// ************************************************************
	// LED drive outputs
	// ************************************************************

	// H-bridge polarity, drive pin steering, offset load
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			led_select_a    <= 1'b0;
			led_select_b    <= 1'b0;
			drive_pin_a     <= 12'h000;
			drive_pin_b     <= 12'h000;
			dc_offset_level <= 12'h000;
		end else if (state == dlps_pkg::ST_IDLE && compare_event) begin
			led_select_a <= led_id;                    // R2 R6
			led_select_b <= ~led_id;                   // R2 R6
			if (led_id ^ pin_swap) begin               // R3 R6
				drive_pin_a <= 12'h000;                // R4
				drive_pin_b <= level[~led_id];         // R7 R11
			end else begin
				drive_pin_a <= level[~led_id];         // R7 R11
				drive_pin_b <= 12'h000;                // R4
			end
			dc_offset_level <= dc_acc[~led_id][31:20]; // R8
		end else if (state == dlps_pkg::ST_OFF || !enable) begin
			drive_pin_a  <= 12'h000;                   // R10
			drive_pin_b  <= 12'h000;                   // R10
			led_select_a <= 1'b0;
			led_select_b <= 1'b0;
		end
	end

	// ************************************************************
	// Results and DC tracking
	// ************************************************************

	// Result stream tagged with the LED that was lit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			conversion_done <= 1'b0;
			result_led_id   <= 1'b0;
			result_tia      <= 12'h000;
			result_ac       <= 12'h000;
			seq_count       <= 16'h0000;
		end else begin
			conversion_done <= cif.done && state == dlps_pkg::ST_AC;  // R10
			if (cif.done && state == dlps_pkg::ST_AC) begin
				result_led_id <= led_id;                // R12
				result_tia    <= cif.tia_result;
				result_ac     <= cif.ac_result;
				seq_count     <= seq_count + 16'h0001;
			end
		end
	end

	// Tracking filter per LED: acc += (in - acc) >> k
	for (genvar i = 0; i < 2; i++) begin : g_track
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				dc_acc[i] <= dlps_pkg::DC_RESET;
			end else if (cif.done && state == dlps_pkg::ST_AC && led_id == 1'(i)) begin
				dc_acc[i] <= dc_acc[i] + 32'($signed({1'b0, cif.tia_result, 20'h00000}
					- {1'b0, dc_acc[i]}) >>> k_shift);    // R14
			end
		end
	end

	// ************************************************************
	// AHB-Lite slave
	// ************************************************************

	// Address phase capture; always zero wait state, OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pending <= 1'b0;
			rd_pending <= 1'b0;
			addr_q     <= 8'h00;
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
		end else begin
			wr_pending <= access && hwrite;
			rd_pending <= access && !hwrite;
			if (access) begin
				addr_q <= haddr[7:0];
			end
		end
	end

	// Write side: control, levels, filter coefficient
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			enable   <= dlps_pkg::CTRL_RESET[dlps_pkg::CTRL_ENABLE_BIT];
			pin_swap <= dlps_pkg::CTRL_RESET[dlps_pkg::CTRL_PIN_SWAP_BIT];
			level[0] <= dlps_pkg::LEVEL_RESET;
			level[1] <= dlps_pkg::LEVEL_RESET;
			k_shift  <= dlps_pkg::K_SHIFT_RESET;
		end else if (wr_pending) begin
			case (addr_q)
				dlps_pkg::CTRL_OFFSET: begin
					enable   <= hwdata[dlps_pkg::CTRL_ENABLE_BIT];
					pin_swap <= hwdata[dlps_pkg::CTRL_PIN_SWAP_BIT];  // R3
				end
				dlps_pkg::RED_LEVEL_OFFSET: begin
					level[0] <= hwdata[11:0];           // R11
				end
				dlps_pkg::IR_LEVEL_OFFSET: begin
					level[1] <= hwdata[11:0];           // R11
				end
				dlps_pkg::K_SHIFT_OFFSET: begin
					k_shift <= hwdata[3:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Done flag: set wins over a status write-one-to-clear
	assign set_done = cif.done && state == dlps_pkg::ST_AC;
	assign clr_done = wr_pending && addr_q == dlps_pkg::STATUS_OFFSET && hwdata[0];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			done_flag <= 1'b0;
		end else if (set_done) begin
			done_flag <= 1'b1;
		end else if (clr_done) begin
			done_flag <= 1'b0;
		end
	end

	// Read data registered in the address phase's following cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (access && !hwrite) begin
			case (haddr[7:0])
				dlps_pkg::CTRL_OFFSET:       hrdata <= {30'h0, pin_swap, enable};
				dlps_pkg::RED_LEVEL_OFFSET:  hrdata <= {20'h0, level[0]};
				dlps_pkg::IR_LEVEL_OFFSET:   hrdata <= {20'h0, level[1]};
				dlps_pkg::K_SHIFT_OFFSET:    hrdata <= {28'h0, k_shift};
				dlps_pkg::STATUS_OFFSET:     hrdata <= {25'h0, state, led_id, done_flag};
				dlps_pkg::RED_DC_OFFSET:     hrdata <= {16'h0, dc_acc[0][31:16]};
				dlps_pkg::IR_DC_OFFSET:      hrdata <= {16'h0, dc_acc[1][31:16]};
				dlps_pkg::TIA_RESULT_OFFSET: hrdata <= {19'h0, result_led_id, result_tia};
				dlps_pkg::AC_RESULT_OFFSET:  hrdata <= {19'h0, result_led_id, result_ac};
				dlps_pkg::SEQ_COUNT_OFFSET:  hrdata <= {16'h0, seq_count};
				default:                     hrdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule
`default_nettype wire

// File: tb/dlps_front_model.sv
// Front end model: photodiode and amplifiers seen by the sequencer
// Assumes the drive pins and offset level come straight from the sequencer
`timescale 1ns/1ps
`default_nettype none
module dlps_front_model (
	// LED drive and offset
	input  wire logic [11:0] drive_pin_a,
	input  wire logic [11:0] drive_pin_b,
	input  wire logic [11:0] dc_offset_level,
	// Amplifier outputs
	output logic      [11:0] tia_sample,
	output logic      [11:0] ac_sample
);
	// ********
	// Light path
	// ********
	// Dark gives zero; lit gives half the drive level
	assign tia_sample = (drive_pin_a | drive_pin_b) >> 1;
	// Second stage sees only the difference to the offset
	assign ac_sample  = tia_sample - dc_offset_level;
endmodule
`default_nettype wire

// File: tb/dlps_sequencer_chk.sv
// Checker on the sequencer ports: LED selects, drive pins, done pulse
// Assumes it is bound to the sequencer and sees its ports only
`timescale 1ns/1ps
`default_nettype none
module dlps_sequencer_chk #(
	parameter int PERIOD_CYCLES = dlps_pkg::PERIOD_CYCLES,
	parameter int CONV_CYCLES   = dlps_pkg::CONV_CYCLES
) (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// Watched outputs
	input  wire logic        led_select_a,
	input  wire logic        led_select_b,
	input  wire logic [11:0] drive_pin_a,
	input  wire logic [11:0] drive_pin_b,
	input  wire logic        conversion_done,
	input  wire logic        result_led_id
);
	localparam int DONE_LO = dlps_pkg::SETTLE_CYCLES;
	localparam int DONE_HI = DONE_LO + 2 * CONV_CYCLES + 8;
	logic        lit;
	logic        lit_q;
	logic        rise;
	logic        seen;
	logic        last_b;
	logic [31:0] gap;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ********
	// Time since the last LED switch-on
	// ********
	assign lit  = led_select_a | led_select_b;
	assign rise = lit & ~lit_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lit_q  <= 1'b0;
			gap    <= 32'h0;
			seen   <= 1'b0;
			last_b <= 1'b0;
		end else begin
			lit_q <= lit;
			gap   <= rise ? 32'h0 : gap + 32'h1;
			if (rise) begin
				seen   <= 1'b1;
				last_b <= led_select_b;
			end
		end
	end
	// ********
	// Properties
	// ********
	sequence led_on_s;
		$rose(lit);
	endsequence
	sequence led_dark_s;
		!lit && drive_pin_a == 12'h000 && drive_pin_b == 12'h000;
	endsequence
	one_led_a: assert property (!(led_select_a && led_select_b))
		else $error("both LED selects high");
	one_pin_a: assert property (!(drive_pin_a != 12'h000 && drive_pin_b != 12'h000))
		else $error("both drive pins driven");
	pin_lit_a: assert property (drive_pin_a != 12'h000 || drive_pin_b != 12'h000 |-> lit)
		else $error("drive level with no LED selected");
	done_pulse_a: assert property (conversion_done |=> !conversion_done)
		else $error("done longer than one cycle");
	done_lit_a: assert property (conversion_done |-> lit)
		else $error("done while LED dark");
	led_off_a: assert property (conversion_done |=> led_dark_s)
		else $error("LED not switched off after done");
	done_time_a: assert property (led_on_s |-> ##[DONE_LO:DONE_HI] conversion_done)
		else $error("conversion not done in time");
	result_id_a: assert property (conversion_done |=> result_led_id == $past(led_select_b))
		else $error("result LED identity wrong");
	period_gap_a: assert property (rise && seen |-> gap == 32'(PERIOD_CYCLES - 1))
		else $error("switch-on spacing wrong");
	alternate_a: assert property (rise && seen |-> led_select_b != last_b)
		else $error("LED did not alternate");
endmodule
bind dlps_sequencer dlps_sequencer_chk #(
	.PERIOD_CYCLES(PERIOD_CYCLES),
	.CONV_CYCLES  (CONV_CYCLES)
) i_dlps_sequencer_chk (
	.hclk           (hclk),
	.hresetn        (hresetn),
	.led_select_a   (led_select_a),
	.led_select_b   (led_select_b),
	.drive_pin_a    (drive_pin_a),
	.drive_pin_b    (drive_pin_b),
	.conversion_done(conversion_done),
	.result_led_id  (result_led_id)
);
`default_nettype wire

// File: tb/dlps_sequencer_tb.sv
// Testbench for the sequencer: bus tasks, front end model, result checks
// Assumes the package, design, model and checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
module dlps_sequencer_tb;
	localparam int PER = 400;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        led_select_a;
	logic        led_select_b;
	logic [11:0] drive_pin_a;
	logic [11:0] drive_pin_b;
	logic [11:0] dc_offset_level;
	logic [11:0] tia_sample;
	logic [11:0] ac_sample;
	logic        conversion_done;
	logic        result_led_id;
	logic [11:0] result_tia;
	logic [11:0] result_ac;
	int          fails;
	int          num_checks;
	logic [11:0] lvl [2];
	logic [31:0] acc [2];
	logic        swap;
	logic        id;
	logic [31:0] rd;
	logic [7:0]  offs [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h40};
	logic [31:0] resv [8] = '{32'h0, 32'h800, 32'h800, 32'h6, 32'h4, 32'h800, 32'h800, 32'h0};
	// ********
	// Design, front end and clock
	// ********
	dlps_sequencer #(.PERIOD_CYCLES(PER), .CONV_CYCLES(4)) i_dlps_sequencer (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.led_select_a(led_select_a), .led_select_b(led_select_b),
		.drive_pin_a(drive_pin_a), .drive_pin_b(drive_pin_b),
		.dc_offset_level(dc_offset_level), .tia_sample(tia_sample), .ac_sample(ac_sample),
		.conversion_done(conversion_done), .result_led_id(result_led_id),
		.result_tia(result_tia), .result_ac(result_ac));
	dlps_front_model i_dlps_front_model (
		.drive_pin_a(drive_pin_a), .drive_pin_b(drive_pin_b),
		.dc_offset_level(dc_offset_level), .tia_sample(tia_sample), .ac_sample(ac_sample));
	initial hclk = 1'b0;
	always #2.5 hclk = ~hclk;
	// ********
	// Tasks
	// ********
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One single word transfer; read data taken at the data phase edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		hsize <= 3'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		d = hrdata;
		chk("response", 32'h0, {31'h0, hresp});
	endtask
	// Waits for one done pulse and checks the LED, drive and results
	task automatic at_done();
		int n;
		logic [11:0] lv;
		logic [11:0] off;
		n = 0;
		lv = lvl[id] >> 1;
		off = acc[id][31:20];
		@(posedge hclk);
		#1;
		while (conversion_done !== 1'b1 && n < 2 * PER) begin
			@(posedge hclk);
			#1;
			n++;
		end
		chk("done seen", 1, conversion_done);
		chk("selects", {30'h0, id, ~id}, {led_select_b, led_select_a});
		chk("drive", lvl[id], (id ^ swap) ? drive_pin_a : drive_pin_b);
		chk("idle pin", 0, (id ^ swap) ? drive_pin_b : drive_pin_a);
		chk("offset", off, dc_offset_level);
		chk("led id", id, result_led_id);
		chk("tia", lv, result_tia);
		chk("ac", 12'(lv - off), result_ac);
		acc[id] = acc[id] + 32'($signed({lv, 20'h0} - acc[id]) >>> dlps_pkg::K_SHIFT_RESET);
		@(posedge hclk);
		#1;
		chk("led off", 0, {led_select_a, led_select_b, drive_pin_a, drive_pin_b});
		id = ~id;
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ********
	// Timeout and main sequence
	// ********
	initial begin
		#50000;
		fails++;
		final_report();
	end
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h0;
		hwdata = 32'h0;
		swap = 1'b0;
		id = 1'b1;
		lvl[0] = 12'h246;
		lvl[1] = 12'h9BC;
		acc[0] = dlps_pkg::DC_RESET;
		acc[1] = dlps_pkg::DC_RESET;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		// Reset values, unmapped place last
		for (int i = 0; i < 8; i++) begin
			bus(1'b0, offs[i], 32'h0, rd);
			chk("reset value", resv[i], rd);
		end
		bus(1'b1, dlps_pkg::RED_LEVEL_OFFSET, {20'h0, lvl[0]}, rd);
		bus(1'b1, dlps_pkg::IR_LEVEL_OFFSET, {20'h0, lvl[1]}, rd);
		bus(1'b1, dlps_pkg::CTRL_OFFSET, 32'h1, rd);
		repeat (4) at_done();
		bus(1'b0, dlps_pkg::STATUS_OFFSET, 32'h0, rd);
		chk("done flag", 1, rd & 32'h1);
		bus(1'b0, dlps_pkg::SEQ_COUNT_OFFSET, 32'h0, rd);
		chk("sequence count", 4, rd);
		bus(1'b1, dlps_pkg::STATUS_OFFSET, 32'h1, rd);
		bus(1'b0, dlps_pkg::STATUS_OFFSET, 32'h0, rd);
		chk("flag cleared", 0, rd & 32'h1);
		swap = 1'b1;
		bus(1'b1, dlps_pkg::CTRL_OFFSET, 32'h3, rd);
		repeat (2) at_done();
		// Reset in mid-run while the next LED is lit
		repeat (PER / 2) @(posedge hclk);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		#1;
		chk("in reset", 0, {led_select_a, led_select_b, conversion_done, drive_pin_a, drive_pin_b});
		@(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, dlps_pkg::RED_LEVEL_OFFSET, 32'h0, rd);
		chk("level reset", 32'h800, rd);
		// One sequence on reset levels, then disable ahead of the next switch-on
		id = 1'b1;
		swap = 1'b0;
		lvl[0] = dlps_pkg::LEVEL_RESET;
		lvl[1] = dlps_pkg::LEVEL_RESET;
		acc[0] = dlps_pkg::DC_RESET;
		acc[1] = dlps_pkg::DC_RESET;
		bus(1'b1, dlps_pkg::CTRL_OFFSET, 32'h1, rd);
		at_done();
		bus(1'b1, dlps_pkg::CTRL_OFFSET, 32'h0, rd);
		repeat (PER / 2) @(posedge hclk);
		#1;
		chk("disabled", 0, {led_select_a, led_select_b, drive_pin_a, drive_pin_b});
		final_report();
	end
endmodule
`default_nettype wire
